// File: core/hpba_device.sv
`timescale 1ns/10ps
// Behaviour
// R1: Host presents start address with chip select
// R2: Parallel-latch style: capture address on strobe fall
// R3: Host keeps latch strobe low during burst
// R4: Write: read strobe high, write low
// R5: Write strobe rise stores data byte
// R6: Later write strobe fall advances address
// R7: Latch strobe rise ends parallel-latch burst
// R8: After burst, single access or new burst
// R9: Style select high picks strobe style
// R10: Strobe style: address captured on strobe rise
// R11: Host sets read select before data strobe
// R12: Read data strobe fall drives data out
// R13: Ready asserted after read data settles
// R14: Host waits ready before raising strobe
// R15: Later read strobe fall advances address
// R16: Host keeps read select high in burst
// R17: Burst one direction, contiguous, lowest first
// R18: Address strobe fall ends strobe-style burst
// R19: Eleven-bit address advances by one
// R20: Data drivers off unless selected read
module hpba_device #(
  parameter int DEPTH = hpba_pkg::MEM_DEPTH,
  parameter int SETTLE = hpba_pkg::READ_SETTLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  hpba_if.device bus,
  output logic [hpba_pkg::ADDR_W-1:0] o_latched_addr,
  output logic o_burst_active,
  output logic o_write_pulse,
  output logic [hpba_pkg::DATA_W-1:0] o_write_data
);
  import hpba_pkg::*;

  // ==========================================
  // Input synchronisers
  localparam int SW = 5 + ADDR_W + DATA_W;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  assign sync_in = {bus.cs_n, bus.addr_latch_strobe, bus.read_or_data_strobe_n, bus.wr_rw,
                    bus.bus_style_select, bus.addr, bus.d_bus};

  hpba_sync #(.W(SW)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  logic cs_n_s;
  logic als_s;
  logic rds_n_s;
  logic wr_s;
  logic style_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  assign {cs_n_s, als_s, rds_n_s, wr_s, style_s, addr_s, data_s} = sync_out;

  // Previous samples for edge detection
  logic als_reg;
  logic rds_n_reg;
  logic wr_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      als_reg <= 1'b0;
      rds_n_reg <= 1'b1;
      wr_reg <= 1'b1;
    end else begin
      als_reg <= als_s;
      rds_n_reg <= rds_n_s;
      wr_reg <= wr_s;
    end
  end

  // Sync stages leave reset at zero, which looks like a selected read strobe.
  // Edges stay masked until the sync stages and edge registers hold pin values.
  logic [1:0] warm_reg;
  logic sync_ok;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      warm_reg <= 2'h0;
    end else if (warm_reg != 2'h3) begin
      warm_reg <= warm_reg + 2'h1;
    end
  end
  assign sync_ok = (warm_reg == 2'h3);

  logic alt_style;
  assign alt_style = (style_s == STYLE_ALT); // [R9]
  logic als_rise;
  logic als_fall;
  logic rds_fall;
  logic rds_rise;
  logic wr_fall;
  logic wr_rise;
  assign als_rise = sync_ok && als_s && !als_reg;
  assign als_fall = sync_ok && !als_s && als_reg;
  assign rds_fall = sync_ok && !rds_n_s && rds_n_reg;
  assign rds_rise = sync_ok && rds_n_s && !rds_n_reg;
  assign wr_fall = sync_ok && !wr_s && wr_reg;
  assign wr_rise = sync_ok && wr_s && !wr_reg;

  // Address capture edge differs per style
  logic addr_capture;
  logic burst_end;
  assign addr_capture = !cs_n_s && (alt_style ? als_rise : als_fall); // [R2] [R10]
  assign burst_end = alt_style ? als_fall : als_rise; // [R7] [R18]

  // Read cycle: alt style uses data strobe with R/W high; else read strobe low
  logic read_start;
  logic read_end;
  logic write_start;
  logic write_end;
  assign read_start = !cs_n_s && rds_fall && (alt_style ? wr_s : 1'b1); // [R12]
  assign read_end = rds_rise;
  assign write_start = !cs_n_s && !alt_style && rds_n_s && wr_fall; // [R4]
  assign write_end = !alt_style && wr_rise;

  // ==========================================
  // Burst address tracking
  logic [ADDR_W-1:0] addr_reg;
  logic first_reg;
  logic burst_reg;

  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    addr_inc = a + {{(ADDR_W-1){1'b0}}, 1'b1}; // [R19]
  endfunction : addr_inc

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      addr_reg <= '0;
      first_reg <= 1'b0;
      burst_reg <= 1'b0;
    end else if (addr_capture) begin
      addr_reg <= addr_s;
      first_reg <= 1'b1;
      burst_reg <= 1'b1;
    end else if (burst_end) begin
      burst_reg <= 1'b0;
    end else if (burst_reg && (read_start || write_start)) begin
      // First access uses the latched address as is
      if (first_reg) begin
        first_reg <= 1'b0;
      end else begin
        addr_reg <= addr_inc(addr_reg); // [R6] [R15]
      end
    end
  end

  // ==========================================
  // Register storage
  logic [DATA_W-1:0] mem [DEPTH];
  logic writing_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      writing_reg <= 1'b0;
    end else if (write_start) begin
      writing_reg <= 1'b1;
    end else if (write_end) begin
      writing_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (writing_reg && write_end) begin
      mem[addr_reg] <= data_s; // [R5]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_write_pulse <= 1'b0;
      o_write_data <= '0;
    end else begin
      o_write_pulse <= writing_reg && write_end;
      if (writing_reg && write_end) begin
        o_write_data <= data_s;
      end
    end
  end

  // ==========================================
  // Read sequencing and ready
  typedef enum logic [1:0] {
    HPBA_IDLE = 2'b00,
    HPBA_SETTLE = 2'b01,
    HPBA_READY = 2'b10
  } hpba_rd_e;
  hpba_rd_e rd_state_reg;
  logic [CNT_W-1:0] settle_cnt_reg;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_state_reg <= HPBA_IDLE;
      settle_cnt_reg <= '0;
    end else begin
      case (rd_state_reg)
        HPBA_IDLE: begin
          if (read_start) begin
            rd_state_reg <= HPBA_SETTLE;
            settle_cnt_reg <= '0;
          end
        end
        HPBA_SETTLE: begin
          if (read_end || cs_n_s) begin
            rd_state_reg <= HPBA_IDLE;
          end else if (settle_cnt_reg == CNT_W'(SETTLE - 1)) begin
            rd_state_reg <= HPBA_READY; // [R13]
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 8'h01;
          end
        end
        HPBA_READY: begin
          if (read_end || cs_n_s) begin
            rd_state_reg <= HPBA_IDLE;
          end
        end
        default: rd_state_reg <= HPBA_IDLE;
      endcase
    end
  end

  // Drivers on only while a selected read is in progress
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.d_dev_oe_n <= 1'b1;
      bus.d_dev_out <= '0;
      bus.ready_ack <= 1'b0;
    end else begin
      bus.d_dev_oe_n <= !(rd_state_reg != HPBA_IDLE && !cs_n_s && !rds_n_s); // [R20] [R12]
      bus.d_dev_out <= mem[addr_reg];
      bus.ready_ack <= (rd_state_reg == HPBA_READY) && !cs_n_s && !rds_n_s; // [R13]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_latched_addr <= '0;
      o_burst_active <= 1'b0;
    end else begin
      o_latched_addr <= addr_reg;
      o_burst_active <= burst_reg;
    end
  end
endmodule : hpba_device

// File: core/hpba_pkg.sv
package hpba_pkg;
  // ==========================================
  // Widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 2048;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  // Read data settle time before ready
  localparam int READ_SETTLE_NS = 40;
  localparam int READ_SETTLE_CYC = (READ_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host strobe pulse width
  localparam int STROBE_NS = 30;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ==========================================
  // Host command kinds and bus style value
  localparam logic [1:0] CMD_WRITE_BURST = 2'h0;
  localparam logic [1:0] CMD_READ_BURST = 2'h1;
  localparam logic [0:0] STYLE_ALT = 1'h1;
endpackage : hpba_pkg

// File: core/hpba_if.sv
`timescale 1ns/10ps
interface hpba_if;
  import hpba_pkg::*;
  logic cs_n;
  logic addr_latch_strobe;
  logic read_or_data_strobe_n;
  logic wr_rw;
  logic bus_style_select;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d_host_out;
  logic d_host_oe_n;
  logic [DATA_W-1:0] d_dev_out;
  logic d_dev_oe_n;
  logic ready_ack;
  // ==========================================
  // Shared data wire resolved from enables
  logic [DATA_W-1:0] d_bus;
  assign d_bus = !d_dev_oe_n ? d_dev_out : (!d_host_oe_n ? d_host_out : {DATA_W{1'b1}});

  modport device (
    input cs_n, addr_latch_strobe, read_or_data_strobe_n, wr_rw, bus_style_select, addr, d_bus,
    output d_dev_out, d_dev_oe_n, ready_ack
  );
  modport host (
    output cs_n, addr_latch_strobe, read_or_data_strobe_n, wr_rw, bus_style_select, addr, d_host_out,
    output d_host_oe_n,
    input d_bus, ready_ack
  );
endinterface : hpba_if

// File: core/hpba_sync.sv
`timescale 1ns/10ps
module hpba_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] stage1_reg;
  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stage1_reg <= '0;
      o_sync <= '0;
    end else begin
      stage1_reg <= i_async;
      o_sync <= stage1_reg;
    end
  end
endmodule : hpba_sync

// File: core/hpba_host.sv
`timescale 1ns/10ps
module hpba_host #(
  parameter int PULSE = hpba_pkg::STROBE_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  hpba_if.host bus,
  input wire logic i_start,
  input wire logic [1:0] i_cmd,
  input wire logic i_style,
  input wire logic [hpba_pkg::ADDR_W-1:0] i_addr,
  input wire logic [hpba_pkg::CNT_W-1:0] i_count,
  input wire logic [hpba_pkg::DATA_W-1:0] i_wdata,
  output logic o_wdata_take,
  output logic o_rdata_valid,
  output logic [hpba_pkg::DATA_W-1:0] o_rdata,
  output logic o_busy
);
  import hpba_pkg::*;

  typedef enum logic [2:0] {
    HPBA_H_IDLE = 3'b000,
    HPBA_H_ADDR = 3'b001,
    HPBA_H_LATCH = 3'b010,
    HPBA_H_STROBE = 3'b011,
    HPBA_H_WAIT = 3'b100,
    HPBA_H_GAP = 3'b101,
    HPBA_H_END = 3'b110
  } hpba_host_e;

  hpba_host_e state_reg;
  logic [CNT_W-1:0] tmr_reg;
  logic [CNT_W-1:0] left_reg;
  logic is_read_reg;
  logic alt_reg;

  // Ready pin crosses from device timing
  logic [1:0] rdy_sync_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdy_sync_reg <= 2'b00;
    end else begin
      rdy_sync_reg <= {rdy_sync_reg[0], bus.ready_ack};
    end
  end

  logic tmr_done;
  assign tmr_done = (tmr_reg == CNT_W'(PULSE));

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= HPBA_H_IDLE;
      tmr_reg <= '0;
      left_reg <= '0;
      is_read_reg <= 1'b0;
      alt_reg <= 1'b0;
      bus.cs_n <= 1'b1;
      bus.addr_latch_strobe <= 1'b0;
      bus.read_or_data_strobe_n <= 1'b1;
      bus.wr_rw <= 1'b1;
      bus.bus_style_select <= 1'b0;
      bus.addr <= '0;
      bus.d_host_out <= '0;
      bus.d_host_oe_n <= 1'b1;
      o_wdata_take <= 1'b0;
      o_rdata_valid <= 1'b0;
      o_rdata <= '0;
      o_busy <= 1'b0;
    end else begin
      o_wdata_take <= 1'b0;
      o_rdata_valid <= 1'b0;
      tmr_reg <= tmr_done ? '0 : tmr_reg + 8'h01;
      case (state_reg)
        HPBA_H_IDLE: begin
          tmr_reg <= '0;
          if (i_start && i_count != '0) begin
            is_read_reg <= (i_cmd == CMD_READ_BURST); // [R17]
            alt_reg <= i_style;
            bus.bus_style_select <= i_style;
            left_reg <= i_count;
            bus.addr <= i_addr; // [R1]
            bus.cs_n <= 1'b0;
            bus.addr_latch_strobe <= !i_style;
            o_busy <= 1'b1;
            state_reg <= HPBA_H_ADDR;
          end
        end
        HPBA_H_ADDR: begin
          if (tmr_done) begin
            bus.addr_latch_strobe <= alt_reg;
            bus.wr_rw <= alt_reg ? is_read_reg : 1'b1; // [R11] [R16]
            state_reg <= HPBA_H_LATCH;
          end
        end
        HPBA_H_LATCH: begin
          if (tmr_done) begin
            bus.read_or_data_strobe_n <= !is_read_reg && !alt_reg; // [R4]
            if (!is_read_reg) begin
              bus.d_host_out <= i_wdata;
              bus.d_host_oe_n <= 1'b0;
              o_wdata_take <= 1'b1;
              if (!alt_reg) begin
                bus.wr_rw <= 1'b0;
              end
            end
            state_reg <= HPBA_H_STROBE;
          end
        end
        HPBA_H_STROBE: begin
          if (is_read_reg && rdy_sync_reg[1]) begin
            o_rdata <= bus.d_bus; // [R14]
            o_rdata_valid <= 1'b1;
            bus.read_or_data_strobe_n <= 1'b1;
            state_reg <= HPBA_H_GAP;
          end else if (!is_read_reg && tmr_done) begin
            if (alt_reg) begin
              bus.read_or_data_strobe_n <= 1'b1;
            end else begin
              bus.wr_rw <= 1'b1;
            end
            state_reg <= HPBA_H_GAP;
          end
        end
        HPBA_H_GAP: begin
          bus.d_host_oe_n <= 1'b1;
          if (tmr_done) begin
            left_reg <= left_reg - 8'h01;
            state_reg <= (left_reg == 8'h01) ? HPBA_H_END : HPBA_H_LATCH; // [R3]
          end
        end
        HPBA_H_END: begin
          bus.addr_latch_strobe <= !alt_reg; // [R7] [R18]
          if (tmr_done) begin
            bus.cs_n <= 1'b1;
            bus.addr_latch_strobe <= 1'b0;
            o_busy <= 1'b0;
            state_reg <= HPBA_H_IDLE; // [R8]
          end
        end
        default: state_reg <= HPBA_H_IDLE;
      endcase
    end
  end
endmodule : hpba_host

// File: sim/hpba_chk_sva.sv
`timescale 1ns/10ps
module hpba_chk (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic cs_n,
  input wire logic addr_latch_strobe,
  input wire logic read_or_data_strobe_n,
  input wire logic wr_rw,
  input wire logic bus_style_select,
  input wire logic d_host_oe_n,
  input wire logic d_dev_oe_n,
  input wire logic ready_ack,
  input wire logic [hpba_pkg::DATA_W-1:0] d_bus
);
  import hpba_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==========================================
  // Device side
  a_drv_idle_off: assert property (cs_n [*6] |-> d_dev_oe_n)
    else $error("data drivers on while deselected");
  a_no_bus_fight: assert property (d_dev_oe_n || d_host_oe_n)
    else $error("both ends drive the data bus");
  a_read_drive_on: assert property ($fell(read_or_data_strobe_n) && wr_rw && !cs_n |-> ##[1:12] !d_dev_oe_n)
    else $error("read strobe did not turn drivers on");
  a_ready_in_time: assert property ($fell(read_or_data_strobe_n) && wr_rw && !cs_n |-> ##[1:20] ready_ack)
    else $error("ready late after read strobe");
  a_ready_data_held: assert property (ready_ack && $past(ready_ack) |-> $stable(d_bus) && !d_dev_oe_n)
    else $error("read data moved while ready");
  // ==========================================
  // Host side
  a_wait_for_ready: assert property ($rose(read_or_data_strobe_n) && !cs_n |-> $past(ready_ack))
    else $error("strobe raised before ready");
  a_rw_read_held: assert property (bus_style_select && !cs_n && !read_or_data_strobe_n |-> wr_rw)
    else $error("read select low under data strobe");
  a_wr_rd_high: assert property (!bus_style_select && !wr_rw |-> read_or_data_strobe_n)
    else $error("read strobe low during write");
  a_latch_low_burst: assert property (!bus_style_select && !(read_or_data_strobe_n && wr_rw) |-> !addr_latch_strobe)
    else $error("latch strobe high during transfer");
  a_cs_at_latch: assert property ($rose(addr_latch_strobe) |-> !cs_n)
    else $error("address strobe without chip select");
endmodule : hpba_chk

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
  import hpba_pkg::*;
  logic i_clk, i_reset, i_start, i_style, wdata_take, rdata_valid, busy, burst_act, wr_pulse;
  logic [1:0] i_cmd;
  logic [ADDR_W-1:0] i_addr, lat_addr;
  logic [CNT_W-1:0] i_count;
  logic [DATA_W-1:0] i_wdata, rdata, wr_data;
  logic [DATA_W-1:0] rd_q[$];
  logic [DATA_W-1:0] wd_q[$];
  logic [ADDR_W-1:0] wa_q[$];
  int fail_count, compares, cycles;

  hpba_if bus_if ();
  hpba_device u_hpba_device (.i_clk(i_clk), .i_reset(i_reset), .bus(bus_if), .o_latched_addr(lat_addr),
    .o_burst_active(burst_act), .o_write_pulse(wr_pulse), .o_write_data(wr_data));
  hpba_host u_hpba_host (.i_clk(i_clk), .i_reset(i_reset), .bus(bus_if), .i_start(i_start), .i_cmd(i_cmd),
    .i_style(i_style), .i_addr(i_addr), .i_count(i_count), .i_wdata(i_wdata), .o_wdata_take(wdata_take),
    .o_rdata_valid(rdata_valid), .o_rdata(rdata), .o_busy(busy));
  hpba_chk u_hpba_chk (.i_clk(i_clk), .i_reset(i_reset), .cs_n(bus_if.cs_n),
    .addr_latch_strobe(bus_if.addr_latch_strobe), .read_or_data_strobe_n(bus_if.read_or_data_strobe_n),
    .wr_rw(bus_if.wr_rw), .bus_style_select(bus_if.bus_style_select), .d_host_oe_n(bus_if.d_host_oe_n),
    .d_dev_oe_n(bus_if.d_dev_oe_n), .ready_ack(bus_if.ready_ack), .d_bus(bus_if.d_bus));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ==========================================
  // Monitors and hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (!i_reset && wr_pulse === 1'b1) begin
      wa_q.push_back(lat_addr);
      wd_q.push_back(wr_data);
    end
    if (!i_reset && rdata_valid === 1'b1) rd_q.push_back(rdata);
    if (cycles == 20000) begin
      fail_count++;
      $display("[FAIL] t=%0t timeout exp=%h got=%h", $time, 1'b0, 1'b1);
      give_verdict();
    end
  end

  // Next byte offered as soon as the host took one
  always @(posedge i_clk) if (wdata_take === 1'b1) #1 i_wdata = i_wdata + 8'h01;

  task check_data(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check_data

  task check_addr(input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check_addr

  task run_burst(input logic [1:0] cmd, input logic st, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] n);
    int g;
    @(posedge i_clk);
    #1;
    i_cmd = cmd;
    i_style = st;
    i_addr = a;
    i_count = n;
    i_start = 1'b1;
    @(posedge i_clk);
    #1;
    i_start = 1'b0;
    g = 0;
    while (busy !== 1'b0 && g < 3000) begin
      @(posedge i_clk);
      #1;
      g++;
    end
    if (g >= 3000) begin
      fail_count++;
      $display("[FAIL] t=%0t burst hang exp=%h got=%h", $time, 1'b0, busy);
    end
    // Device lags the pins by its synchronisers
    repeat (8) @(posedge i_clk);
    #1;
    check_data(8'h00, 8'(burst_act));
  endtask : run_burst

  task read_burst(input logic st, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] n, input logic [7:0] e0);
    rd_q.delete();
    run_burst(CMD_READ_BURST, st, a, n);
    check_data(8'(n), 8'(rd_q.size()));
    for (int k = 0; k < int'(n); k++) begin
      check_data(e0 + 8'(k), rd_q[k]);
    end
  endtask : read_burst

  // ==========================================
  // Scenarios
  task t_write_wrap;
    wa_q.delete();
    wd_q.delete();
    run_burst(CMD_WRITE_BURST, 1'b0, 11'h7FE, 8'h03);
    check_data(8'h03, 8'(wa_q.size()));
    for (int k = 0; k < 3; k++) begin
      check_addr(11'h7FE + 11'(k), wa_q[k]);
      check_data(8'hC0 + 8'(k), wd_q[k]);
    end
    $display("test write_wrap done");
  endtask : t_write_wrap

  task t_read_alt;
    read_burst(STYLE_ALT, 11'h7FE, 8'h03, 8'hC0);
    $display("test read_alt done");
  endtask : t_read_alt

  task t_read_latch;
    read_burst(1'b0, 11'h7FF, 8'h02, 8'hC1);
    $display("test read_latch done");
  endtask : t_read_latch

  task t_single_write;
    wa_q.delete();
    run_burst(CMD_WRITE_BURST, 1'b0, 11'h005, 8'h01);
    check_addr(11'h005, wa_q[0]);
    read_burst(STYLE_ALT, 11'h005, 8'h01, 8'hC3);
    $display("test single_write done");
  endtask : t_single_write

  task t_idle_bus;
    check_data(8'hFF, bus_if.d_bus);
    check_data(8'h01, 8'(bus_if.d_dev_oe_n));
    $display("test idle_bus done");
  endtask : t_idle_bus

  task give_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    i_reset = 1'b1;
    i_start = 1'b0;
    i_cmd = CMD_WRITE_BURST;
    i_style = 1'b0;
    i_addr = '0;
    i_count = '0;
    i_wdata = 8'hC0;
    repeat (20) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    repeat (3) @(posedge i_clk);
    t_write_wrap();
    t_read_alt();
    t_read_latch();
    t_single_write();
    t_idle_bus();
    give_verdict();
  end
endmodule : tb
